// ---- core/sdlst_map.vh ----
// Register map, field positions and timing counts of the line status tracker
`ifndef SDLST_MAP_VH
`define SDLST_MAP_VH
// Byte offsets
`define SDLST_OFS_PSTATE   12'h000
`define SDLST_OFS_CMD      12'h004
`define SDLST_OFS_CTRL     12'h008
`define SDLST_OFS_IRQSTAT  12'h00C
`define SDLST_OFS_IRQMASK  12'h010
// present_state bit positions
`define SDLST_PS_COMMAND_LINE_INHIBIT      0
`define SDLST_PS_DCI       1
`define SDLST_PS_DLA       2
`define SDLST_PS_WTA       8
`define SDLST_PS_RTA       9
// Command register fields
`define SDLST_CMD_READ     4
`define SDLST_CMD_RSP_LO   16
`define SDLST_CMD_RSP_HI   17
`define SDLST_CMD_DATA     21
`define SDLST_CMD_LAUNCH_LANE 3
// Response type codes
`define SDLST_RSP_NONE     2'h0
`define SDLST_RSP_BUSY     2'h3
// Control register bits, write one to act
`define SDLST_CTRL_GAP     0
`define SDLST_CTRL_CONT    1
`define SDLST_CTRL_CMDRST  2
`define SDLST_CTRL_DATRST  3
// Interrupt status bits
`define SDLST_IRQ_TC       0
// Bus clock edges of idle line before busy ends
`define SDLST_IDLE_EDGES   4'h8
`define SDLST_ZERO32       32'h00000000
`endif

// ---- core/sdlst_core.v ----
// Command and data line status tracker with APB register access
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "sdlst_map.vh"
module sdlst_core
#(
    parameter IDLE_W = 4
)
(
    // Clock and reset
    input  wire        CORE_CLK,
    input  wire        RESET,
    // APB slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    input  wire [3:0]  PSTRB,
    output reg  [31:0] PRDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    // Card bus pins, sampled from outside this clock domain
    input  wire        SD_CLK,
    input  wire        SD_DAT0,
    // Transfer engine events, one-cycle pulses on CORE_CLK
    input  wire        CMD_END_SENT,
    input  wire        AUTO_STOP_SENT,
    input  wire        RESP_END,
    input  wire        CMD_CRC_ERR,
    input  wire        CMD_END_BIT_ERR,
    input  wire        AUTO_STOP_NOT_EXEC,
    input  wire        CMD_TIMEOUT_ERR,
    input  wire        CRC_STATUS_LAST,
    input  wire        READ_LAST_END,
    input  wire        READ_WAIT_START,
    input  wire        READ_OUT_DONE,
    input  wire        GAP_STOPPED,
    // Requests towards the transfer engine
    output reg         CMD_LAUNCH,
    output reg         GAP_REQUEST,
    output reg         CONTINUE_REQUEST,
    // Interrupt
    output wire        IRQ
);

    // Address decode shared by read and write paths.
    // Every register takes one aligned word, so the full byte address
    // is compared and the low two bits must be zero for a hit.
    // Kept as a function so the read mux, the write strobes and the
    // error answer all agree on one decode.
    function is_ofs;
        input [11:0] a;
        input [11:0] o;
        begin
            is_ofs = (a == o);
        end
    endfunction

    // Access phase qualifiers.
    // A write takes effect only in the access phase, never in setup,
    // so a master that stalls in setup cannot launch a command twice.
    // The hit term covers every mapped word; anything else is refused.
    // Refused writes change nothing and refused reads return zero.
    wire acc = PSEL & PENABLE;
    wire wr  = acc & PWRITE;
    wire hit = is_ofs(PADDR, `SDLST_OFS_PSTATE) | is_ofs(PADDR, `SDLST_OFS_CMD)
             | is_ofs(PADDR, `SDLST_OFS_CTRL) | is_ofs(PADDR, `SDLST_OFS_IRQSTAT)
             | is_ofs(PADDR, `SDLST_OFS_IRQMASK);

    // Zero wait states; unmapped addresses answer with an error.
    // Every register is a plain flop or a mux of flops, so no wait is needed.
    // A slower fabric would have to stretch ready here.
    assign PREADY  = 1'b1;
    assign PSLVERR = acc & ~hit;

    // State of the tracker.
    // The flags below are the whole of the software-visible status.
    // The busy helpers track a pending busy phase after a response or
    // after the last write block, and the gap flag arms a continue.
    // The direction flag remembers which way the stopped transfer ran,
    // so a continue resumes it without software saying so again.
    // The pin synchronisers sit at the end of the list.
    reg [31:0] cmd_r;
    reg        command_line_inhibit_r;
    reg        dla_r;
    reg        wta_r;
    reg        rta_r;
    reg        busy_cmd_r;
    reg        busy_wait_r;
    reg        busy_pending_r;
    reg        wr_dir_r;
    reg        gap_r;
    reg        dci_prev_r;
    reg        irq_stat_r;
    reg        irq_mask_r;
    reg [IDLE_W-1:0] idle_cnt_r;
    reg        clk_s1_r;
    reg        clk_s2_r;
    reg        clk_s3_r;
    reg        dat_s1_r;
    reg        dat_s2_r;

    // Decoded strobes and combinational status terms.
    // The launch strobe keys on byte lane 3 only: software may write the
    // lower bytes of the command word first without starting anything.
    // The continue strobe is ignored unless a gap stop or read wait is
    // pending, which keeps a stray write from reopening a finished transfer.
    // Any response error keeps the command inhibit up; only a command line
    // reset clears it then.
    wire cmd_wr    = wr & is_ofs(PADDR, `SDLST_OFS_CMD);
    wire ctrl_wr   = wr & is_ofs(PADDR, `SDLST_OFS_CTRL);
    wire launch    = cmd_wr & PSTRB[`SDLST_CMD_LAUNCH_LANE];
    wire cmd_rst   = ctrl_wr & PWDATA[`SDLST_CTRL_CMDRST];
    wire dat_rst   = ctrl_wr & PWDATA[`SDLST_CTRL_DATRST];
    wire cont      = ctrl_wr & PWDATA[`SDLST_CTRL_CONT] & gap_r;
    wire gap_req   = ctrl_wr & PWDATA[`SDLST_CTRL_GAP];
    wire [1:0] rsp = cmd_r[`SDLST_CMD_RSP_HI:`SDLST_CMD_RSP_LO];
    wire is_data   = cmd_r[`SDLST_CMD_DATA];
    wire is_read   = cmd_r[`SDLST_CMD_READ];
    wire resp_err  = CMD_CRC_ERR | CMD_END_BIT_ERR | AUTO_STOP_NOT_EXEC | CMD_TIMEOUT_ERR;
    wire dci       = dla_r | rta_r | busy_cmd_r;
    wire sd_rise   = clk_s2_r & ~clk_s3_r;
    wire busy_done = busy_wait_r & sd_rise & dat_s2_r
                   & (idle_cnt_r == `SDLST_IDLE_EDGES - 4'h1);

    // Two-flop synchronisers for the card pins; only the second stage is read.
    // The third clock stage exists only to find rising bus clock edges.
    // The data line resets to its idle level, high, so that no false busy
    // is seen in the cycles after reset.
    // Edges are seen about two core cycles late; that delay is the same
    // for clock and data, so their relation is preserved.
    // The bus clock must stay well below half the core clock for this.
    always @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            clk_s1_r <= 1'b0;
            clk_s2_r <= 1'b0;
            clk_s3_r <= 1'b0;
            dat_s1_r <= 1'b1;
            dat_s2_r <= 1'b1;
        end
        else
        begin
            clk_s1_r <= SD_CLK;
            clk_s2_r <= clk_s1_r;
            clk_s3_r <= clk_s2_r;
            dat_s1_r <= SD_DAT0;
            dat_s2_r <= dat_s1_r;
        end
    end

    // Idle counter: counts bus clock edges with the data line high, restarts on busy.
    // It runs only while a busy phase is awaited, and any low sample
    // starts the count again, so a glitch cannot end busy early.
    // With the bus clock stopped the count simply holds; the busy phase
    // then ends only when the clock runs again.
    // The width parameter must hold the count of idle edges.
    always @(posedge CORE_CLK)
    begin
        if (RESET || !busy_wait_r || busy_done)
            idle_cnt_r <= {IDLE_W{1'b0}};
        else if (sd_rise)
        begin
            if (dat_s2_r)
                idle_cnt_r <= idle_cnt_r + {{(IDLE_W-1){1'b0}}, 1'b1};
            else
                idle_cnt_r <= {IDLE_W{1'b0}};
        end
    end

    // Command register and one-cycle requests to the transfer engine.
    // Requests are registered so the engine sees clean one-cycle pulses
    // one cycle after the bus write that caused them.
    // The command word is kept whole so the response type and direction
    // are known when the engine reports the end bit.
    // A gap request is passed on whether or not a transfer is running;
    // the engine decides whether it applies.
    always @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            cmd_r            <= `SDLST_ZERO32;
            CMD_LAUNCH       <= 1'b0;
            GAP_REQUEST      <= 1'b0;
            CONTINUE_REQUEST <= 1'b0;
        end
        else
        begin
            if (cmd_wr)
                cmd_r <= PWDATA;
            CMD_LAUNCH       <= launch;
            GAP_REQUEST      <= gap_req;
            CONTINUE_REQUEST <= cont;
        end
    end

    // Command line inhibit.
    // Reset and the command line reset win over everything.
    // A launch wins over a clear in the same cycle, because the new command
    // owns the line from then on.
    // Without a response the command end bit frees the line; with one,
    // only a clean response end does.
    // After a timeout or any other response error the flag stays set,
    // so software must reset the command line before the next command.
    // The end bit of an automatic stop is reported by the engine alone.
    always @(posedge CORE_CLK)
    begin
        if (RESET || cmd_rst)
            command_line_inhibit_r <= 1'b0;
        else if (launch)
            command_line_inhibit_r <= 1'b1;
        else if (CMD_END_SENT && rsp == `SDLST_RSP_NONE)
            command_line_inhibit_r <= 1'b0;
        else if (RESP_END && !resp_err)
            command_line_inhibit_r <= 1'b0;
        // Auto stop end bits are not filtered here; they clear this flag like any command end
    end

    // Data line flags; the read wait stop is a gap stop too, so continue resumes it.
    // A data command end bit opens a transfer in the direction of the
    // command word; an automatic stop end bit leaves the flags alone.
    // A write stopped at a gap, or finished by its last CRC status,
    // still waits for the card's busy phase before the line is free.
    // Reads free the line at the last block end bit or at read wait,
    // while read active lasts until the data has been drained or a gap stop.
    // A command expecting busy holds the data inhibit from launch until
    // the busy phase after its response has ended.
    // Trade-off: gap, CRC status and read events in the cycle of a continue are ignored, as the
    // engine cannot report an end while it is being restarted.
    always @(posedge CORE_CLK)
    begin
        if (RESET || dat_rst)
        begin
            dla_r          <= 1'b0;
            wta_r          <= 1'b0;
            rta_r          <= 1'b0;
            wr_dir_r       <= 1'b0;
            gap_r          <= 1'b0;
            busy_wait_r    <= 1'b0;
            busy_cmd_r     <= 1'b0;
            busy_pending_r <= 1'b0;
        end
        else
        begin
            if (CMD_END_SENT && is_data && !AUTO_STOP_SENT)
            begin
                dla_r    <= 1'b1;
                wr_dir_r <= ~is_read;
                wta_r    <= ~is_read;
                rta_r    <= is_read;
                gap_r    <= 1'b0;
            end
            else if (cont)
            begin
                dla_r <= 1'b1;
                wta_r <= wr_dir_r;
                rta_r <= ~wr_dir_r;
                gap_r <= 1'b0;
            end
            else
            begin
                if (GAP_STOPPED)
                    gap_r <= 1'b1;
                if (READ_WAIT_START)
                    gap_r <= 1'b1;
                if (CRC_STATUS_LAST || (GAP_STOPPED && wr_dir_r))
                begin
                    wta_r       <= 1'b0;
                    busy_wait_r <= 1'b1;
                end
                if (!wr_dir_r && (READ_LAST_END || READ_WAIT_START))
                    dla_r <= 1'b0;
                if (READ_OUT_DONE || (GAP_STOPPED && !wr_dir_r))
                    rta_r <= 1'b0;
            end
            // Command expecting busy holds the data inhibit until busy ends
            if (launch && PWDATA[`SDLST_CMD_RSP_HI:`SDLST_CMD_RSP_LO] == `SDLST_RSP_BUSY)
                busy_cmd_r <= 1'b1;
            if (launch && PWDATA[`SDLST_CMD_RSP_HI:`SDLST_CMD_RSP_LO] == `SDLST_RSP_BUSY)
                busy_pending_r <= 1'b1;
            else if (busy_pending_r && RESP_END)
            begin
                busy_pending_r <= 1'b0;
                busy_wait_r    <= 1'b1;
            end
            if (busy_done)
            begin
                busy_wait_r <= 1'b0;
                busy_cmd_r  <= 1'b0;
                if (wr_dir_r)
                    dla_r <= 1'b0;
            end
        end
    end

    // Transfer complete flag: set on falling inhibit; set beats a same-cycle clear.
    // The previous inhibit value resets low, matching the inhibit itself,
    // so no false fall is seen after reset.
    // Software clears the flag by writing a one; a completion in that
    // same cycle is kept, so no event is ever lost.
    // The mask only gates the interrupt line, never the status bit.
    always @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            dci_prev_r <= 1'b0;
            irq_stat_r <= 1'b0;
            irq_mask_r <= 1'b0;
        end
        else
        begin
            dci_prev_r <= dci;
            if (dci_prev_r && !dci)
                irq_stat_r <= 1'b1;
            else if (wr && is_ofs(PADDR, `SDLST_OFS_IRQSTAT) && PWDATA[`SDLST_IRQ_TC])
                irq_stat_r <= 1'b0;
            if (wr && is_ofs(PADDR, `SDLST_OFS_IRQMASK))
                irq_mask_r <= PWDATA[`SDLST_IRQ_TC];
        end
    end

    // Level interrupt, high while the unmasked status bit is set.
    // Built from flops only, so it cannot glitch.
    assign IRQ = irq_stat_r & irq_mask_r;

    // Read mux; present_state ignores writes and reserved bits read zero.
    // The data follows the address during the whole transfer; the master
    // takes it at the edge where ready is sampled.
    // The control word is write-only and reads back zero, as do unmapped
    // addresses, which answer with an error as well.
    // Buffer flags are not tracked here and read zero.
    always @*
    begin
        PRDATA = `SDLST_ZERO32;
        if (is_ofs(PADDR, `SDLST_OFS_PSTATE))
        begin
            PRDATA[`SDLST_PS_COMMAND_LINE_INHIBIT] = command_line_inhibit_r;
            PRDATA[`SDLST_PS_DCI]  = dci;
            PRDATA[`SDLST_PS_DLA]  = dla_r;
            PRDATA[`SDLST_PS_WTA]  = wta_r;
            PRDATA[`SDLST_PS_RTA]  = rta_r;
        end
        else if (is_ofs(PADDR, `SDLST_OFS_CMD))
            PRDATA = cmd_r;
        else if (is_ofs(PADDR, `SDLST_OFS_IRQSTAT))
            PRDATA[`SDLST_IRQ_TC] = irq_stat_r;
        else if (is_ofs(PADDR, `SDLST_OFS_IRQMASK))
            PRDATA[`SDLST_IRQ_TC] = irq_mask_r;
    end

endmodule // sdlst_core
`default_nettype wire

// ---- tb/sdlst_monitor.sv ----
// Port-level assertions for the line status tracker
`timescale 1ns/100ps
`default_nettype none
module sdlst_monitor
#(
    parameter IDLE_W = 4
)
(
    // Clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RESET,
    // Register bus
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0]  PSTRB,
    input wire logic [31:0] PRDATA,
    // Engine requests and interrupt
    input wire logic        CMD_LAUNCH,
    input wire logic        CONTINUE_REQUEST,
    input wire logic        IRQ
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    // Access phase decodes; status reads only, as flags are defined there
    wire rd = PSEL && PENABLE && !PWRITE && PADDR == 12'h000;
    wire wr = PSEL && PENABLE && PWRITE;
    wire go = wr && PADDR == 12'h004 && PSTRB[3];
    chk_launch_follows: assert property (go |=> CMD_LAUNCH)
        else $error("launch missing");
    chk_launch_cause: assert property (CMD_LAUNCH |-> $past(go))
        else $error("launch without write");
    chk_command_line_inhibit_after_go: assert property (rd && $past(CMD_LAUNCH, 2) |-> PRDATA[0])
        else $error("command inhibit low after launch");
    chk_continue_cause: assert property (CONTINUE_REQUEST |-> $past(wr && PADDR == 12'h008 && PWDATA[1]))
        else $error("continue without write");
    chk_reserved_zero: assert property (rd |-> (PRDATA & 32'hFFFFFCF8) == 32'h0)
        else $error("reserved status bits set");
    chk_irq_reset: assert property ($past(RESET) |-> !IRQ)
        else $error("interrupt after reset");
    chk_inhibit_cover: assert property (rd && (PRDATA[2] || PRDATA[9]) |-> PRDATA[1])
        else $error("data inhibit low while line busy");
    chk_wta_dla: assert property (rd && PRDATA[8] |-> PRDATA[2])
        else $error("write active without line active");
endmodule // sdlst_monitor
bind sdlst_core sdlst_monitor #(.IDLE_W(IDLE_W)) mon (.CORE_CLK, .RESET, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA, .CMD_LAUNCH, .CONTINUE_REQUEST, .IRQ);
`default_nettype wire

// ---- tb/sdlst_card.sv ----
// Card model: bus clock within frames and busy on data line 0
`timescale 1ns/100ps
`default_nettype none
module sdlst_card
(
    // Frame and busy controls
    input  wire logic run,
    input  wire logic busy,
    // Card pins
    output var  logic sd_clk,
    output wire logic sd_dat0
);
    // Clock stands low between frames; phase unrelated to the core clock
    initial
    begin
        sd_clk = 1'h0;
        #13.7;
        forever
        begin
            #80;
            sd_clk = run ? !sd_clk : 1'h0;
        end
    end
    // Busy holds the line low; released, the pull-up brings it high
    assign sd_dat0 = busy ? 1'h0 : 1'h1;
endmodule // sdlst_card
`default_nettype wire

// ---- tb/sdlst_core_tb.sv ----
// Self-checking bench for the line status tracker
`timescale 1ns/100ps
`default_nettype none
module sdlst_core_tb;
    logic        clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic        run = 1'h0, busy = 1'h0, slv;
    logic [11:0] paddr = 12'h000, ev = 12'h000;
    logic [31:0] pwdata = 32'h0, rdata;
    logic [3:0]  pstrb = 4'hF;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq, sd_clk, sd_dat0, gapr;
    integer      err_count = 0, tests_run = 0, cyc = 0;
    sdlst_core dut
    (
        .CORE_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SD_CLK(sd_clk), .SD_DAT0(sd_dat0), .CMD_END_SENT(ev[0]),
        .AUTO_STOP_SENT(ev[1]), .RESP_END(ev[2]), .CMD_CRC_ERR(ev[3]),
        .CMD_END_BIT_ERR(ev[4]), .AUTO_STOP_NOT_EXEC(ev[5]), .CMD_TIMEOUT_ERR(ev[6]),
        .CRC_STATUS_LAST(ev[7]), .READ_LAST_END(ev[8]), .READ_WAIT_START(ev[9]),
        .READ_OUT_DONE(ev[10]), .GAP_STOPPED(ev[11]), .CMD_LAUNCH(), .GAP_REQUEST(gapr),
        .CONTINUE_REQUEST(), .IRQ(irq)
    );
    sdlst_card card (.run(run), .busy(busy), .sd_clk(sd_clk), .sd_dat0(sd_dat0));
    // One APB transfer, held until ready is seen at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1)
            @(posedge clk);
        rdata = prdata;
        slv = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task cmp(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Flag bits of the status register
    task st(input logic [31:0] e);
        apb(1'h0, 12'h000, 32'h0);
        cmp(rdata & 32'h307, e);
    endtask
    // Engine events for one cycle; error levels ride with the response end
    task pulse(input logic [11:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 12'h000;
    endtask
    task t_regs;
        apb(1'h0, 12'h000, 32'h0);
        cmp(rdata, 32'h0);
        apb(1'h1, 12'h000, 32'hFFFFFFFF);
        st(32'h0);
        apb(1'h0, 12'h020, 32'h0);
        cmp({31'h0, slv}, 32'h1);
    endtask
    // Busy ends only after eight idle bus clocks, so stop at seven first
    task t_write;
        apb(1'h1, 12'h004, 32'h00210000);
        st(32'h001);
        pulse(12'h001);
        st(32'h107);
        pulse(12'h004);
        st(32'h106);
        pulse(12'h080);
        st(32'h006);
        run <= 1'h1;
        busy <= 1'h1;
        repeat (3) @(posedge sd_clk);
        @(negedge sd_clk);
        busy <= 1'h0;
        repeat (7) @(posedge sd_clk);
        st(32'h006);
        repeat (3) @(posedge sd_clk);
        run <= 1'h0;
        st(32'h000);
        cmp({31'h0, irq}, 32'h0);
        apb(1'h1, 12'h010, 32'h1);
        apb(1'h0, 12'h00C, 32'h0);
        cmp(rdata & 32'h1, 32'h1);
        cmp({31'h0, irq}, 32'h1);
        apb(1'h1, 12'h00C, 32'h1);
        apb(1'h0, 12'h00C, 32'h0);
        cmp({rdata[31:1], irq}, 32'h0);
    endtask
    // Stop at gap on a write, then continue and finish the last block
    task t_gap;
        apb(1'h1, 12'h004, 32'h00210000);
        pulse(12'h001);
        pulse(12'h004);
        st(32'h106);
        apb(1'h1, 12'h008, 32'h1);
        @(negedge clk);
        cmp({31'h0, gapr}, 32'h1);
        pulse(12'h800);
        st(32'h006);
        run <= 1'h1;
        repeat (10) @(posedge sd_clk);
        run <= 1'h0;
        st(32'h000);
        apb(1'h1, 12'h008, 32'h2);
        st(32'h106);
        pulse(12'h080);
        st(32'h006);
        run <= 1'h1;
        repeat (10) @(posedge sd_clk);
        run <= 1'h0;
        st(32'h000);
        apb(1'h1, 12'h00C, 32'h1);
    endtask
    task t_read;
        apb(1'h1, 12'h004, 32'h00210010);
        pulse(12'h001);
        st(32'h207);
        pulse(12'h004);
        pulse(12'h200);
        st(32'h202);
        apb(1'h1, 12'h008, 32'h2);
        st(32'h206);
        pulse(12'h100);
        st(32'h202);
        pulse(12'h400);
        st(32'h000);
        apb(1'h1, 12'h00C, 32'h1);
    endtask
    // Each response error holds the inhibit until a command line reset
    task t_cmd;
        integer i;
        for (i = 0; i < 4; i++)
        begin
            apb(1'h1, 12'h004, 32'h00010000);
            pulse(12'h001);
            pulse(12'h004 | (12'h008 << i));
            st(32'h001);
            apb(1'h1, 12'h008, 32'h4);
            st(32'h000);
        end
        apb(1'h1, 12'h004, 32'h0);
        pulse(12'h001);
        st(32'h000);
        pulse(12'h003);
        st(32'h000);
    endtask
    task close_out;
        if (err_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Core clock
    initial
    begin
        forever
            #2 clk = !clk;
    end
    // Reset, then the scenarios in order
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        t_regs;
        t_write;
        t_gap;
        t_read;
        t_cmd;
        close_out;
    end
    // Watchdog against a hung handshake
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            close_out;
        end
    end
endmodule // sdlst_core_tb
`default_nettype wire
